// >>> mcj_pkg.sv
// Purpose: shared constants and carrier types for the conditional jump decoder
// Assumes: 16-bit instruction words, one code address per word
// Notes: register offsets are byte addresses on a 32-bit Avalon-MM slave
package mcj_pkg;

	// ------------------------------------------------------------------
	// widths
	// ------------------------------------------------------------------
	localparam int PC_W = 10;
	localparam int INSTR_W = 16;
	localparam int START_W = 6;
	localparam int OFFS_W = 5;

	// ------------------------------------------------------------------
	// instruction encodings and field positions
	// ------------------------------------------------------------------
	localparam logic [9:0] ID_REL_OPCODE = 10'h0bd; // bits 15..6 = 0010111101
	localparam int ID_REL_OPC_LSB = 6;
	localparam int ID_REL_SEL_BIT = 5;
	localparam int ID_REL_OFFS_LSB = 0;
	localparam logic [4:0] ST_ABS_OPCODE = 5'h07; // bits 15..11 = 00111
	localparam int ST_ABS_OPC_LSB = 11;
	localparam logic [3:0] ST_ABS_TAIL = 4'h1; // bits 3..0 = 0001
	localparam int ST_ABS_MASK_LSB = 5;
	localparam int ST_ABS_REG_BIT = 4;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam logic [3:0] OFS_JUMP_REG0 = 4'h0;
	localparam logic [3:0] OFS_JUMP_REG1 = 4'h4;
	localparam logic [3:0] OFS_CONTROL = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hc;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int STAT_TAKEN_BIT = 0;
	localparam int STAT_ID_BIT = 1;
	localparam int STAT_START_BIT = 2;
	localparam int STAT_PC_LSB = 16;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [PC_W-1:0] JUMP_REG_RESET = 10'h000;
	localparam logic CTRL_ENABLE_RESET = 1'b1;
	localparam logic [PC_W-1:0] PC_RESET = 10'h000;

	// ------------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic is_id_jump;
		logic is_start_jump;
		logic taken;
		logic [PC_W-1:0] next_pc;
	} mcj_decision_type;

	typedef struct packed {
		logic valid;
		logic taken;
		logic [PC_W-1:0] pc;
	} mcj_pc_type;

endpackage : mcj_pkg

// >>> mcj_jump_eval.sv
// Purpose: combinational decode and condition check of the two jumps
// Assumes: all inputs are on the core clock and stable within the cycle
// Notes: any other word yields the sequential address with taken low
`timescale 1ns/1ps
module mcj_jump_eval (
	// instruction under execution
	input wire logic [mcj_pkg::INSTR_W-1:0] instr_word,
	input wire logic [mcj_pkg::PC_W-1:0] instr_addr,
	// core state
	input wire logic core_id,
	input wire logic [mcj_pkg::START_W-1:0] start_latched,
	input wire logic [mcj_pkg::PC_W-1:0] jump_reg0,
	input wire logic [mcj_pkg::PC_W-1:0] jump_reg1,
	input wire logic enable,
	// result
	output mcj_pkg::mcj_decision_type decision
);

	logic id_hit;
	logic st_hit;
	logic id_cond;
	logic st_cond;
	logic [mcj_pkg::OFFS_W-1:0] offs;
	logic [mcj_pkg::START_W-1:0] start_mask_selector;
	logic core_identity_selector;
	logic jump_register_select;
	logic [mcj_pkg::PC_W-1:0] rel_target;
	logic [mcj_pkg::PC_W-1:0] abs_target;

	// field extraction and pattern match
	always_comb begin
		id_hit = instr_word[mcj_pkg::INSTR_W-1:mcj_pkg::ID_REL_OPC_LSB]
			== mcj_pkg::ID_REL_OPCODE;
		st_hit = (instr_word[mcj_pkg::INSTR_W-1:mcj_pkg::ST_ABS_OPC_LSB]
			== mcj_pkg::ST_ABS_OPCODE) && (instr_word[3:0] == mcj_pkg::ST_ABS_TAIL);
		core_identity_selector = instr_word[mcj_pkg::ID_REL_SEL_BIT];
		offs = instr_word[mcj_pkg::ID_REL_OFFS_LSB +: mcj_pkg::OFFS_W];
		start_mask_selector = instr_word[mcj_pkg::ST_ABS_MASK_LSB +: mcj_pkg::START_W];
		jump_register_select = instr_word[mcj_pkg::ST_ABS_REG_BIT];
	end

	// conditions: selector 0 wants core 0, selector 1 wants core 1
	always_comb begin
		id_cond = (core_identity_selector == core_id);
		st_cond = (start_latched == start_mask_selector);
	end

	// targets; offset sign-extended so -16..15 wraps correctly
	always_comb begin
		rel_target = instr_addr + {{(mcj_pkg::PC_W-mcj_pkg::OFFS_W){offs[4]}}, offs};
		abs_target = jump_register_select ? jump_reg1 : jump_reg0;
	end

	// pick the next counter value
	always_comb begin
		decision.is_id_jump = id_hit;
		decision.is_start_jump = st_hit;
		decision.taken = 1'b0;
		decision.next_pc = instr_addr + 10'h001;
		if (enable && id_hit && id_cond) begin
			decision.taken = 1'b1;
			decision.next_pc = rel_target;
		end else if (enable && st_hit && st_cond) begin
			decision.taken = 1'b1;
			decision.next_pc = abs_target;
		end
	end

endmodule : mcj_jump_eval

// >>> mcj_decode_top.sv
// Purpose: conditional jump decoder between code fetch and program counter
// Assumes: fetch, start latches and core id all run on ref_clk
// Notes: registers reached over Avalon-MM, one wait state per access
//   status is read only; writes to it and to unmapped offsets are dropped
//   clearing the enable bit turns every jump into a plain step
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module mcj_decode_top (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// instruction fetch
	input wire logic instr_valid,
	input wire logic [mcj_pkg::INSTR_W-1:0] instr_word,
	input wire logic [mcj_pkg::PC_W-1:0] instr_addr,
	// core state
	input wire logic core_id,
	input wire logic [mcj_pkg::START_W-1:0] start_latched,
	// program counter load
	output logic pc_load,
	output logic pc_taken,
	output logic [mcj_pkg::PC_W-1:0] core_program_counter,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	mcj_pkg::mcj_decision_type decision;
	mcj_pkg::mcj_pc_type pc_q;
	mcj_pkg::mcj_pc_type pc_d;
	logic [mcj_pkg::PC_W-1:0] jreg0_q;
	logic [mcj_pkg::PC_W-1:0] jreg0_d;
	logic [mcj_pkg::PC_W-1:0] jreg1_q;
	logic [mcj_pkg::PC_W-1:0] jreg1_d;
	logic enable_q;
	logic enable_d;
	logic last_taken_q;
	logic last_taken_d;
	logic last_id_q;
	logic last_id_d;
	logic last_start_q;
	logic last_start_d;
	logic ack_q;
	logic ack_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic bus_req;
	logic wr_go;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------

	// byte-lane merge for a jump register; lanes 2 and 3 carry nothing
	function automatic logic [mcj_pkg::PC_W-1:0] lane_merge(
		input logic [mcj_pkg::PC_W-1:0] old_val,
		input logic [31:0] wdata,
		input logic [3:0] be
	);
		logic [mcj_pkg::PC_W-1:0] merged;
		merged = old_val;
		if (be[0]) merged[7:0] = wdata[7:0];
		if (be[1]) merged[mcj_pkg::PC_W-1:8] = wdata[mcj_pkg::PC_W-1:8];
		return merged;
	endfunction : lane_merge

	// ------------------------------------------------------------------
	// jump decision
	// ------------------------------------------------------------------

	mcj_jump_eval u_eval (
		.instr_word(instr_word),
		.instr_addr(instr_addr),
		.core_id(core_id),
		.start_latched(start_latched),
		.jump_reg0(jreg0_q),
		.jump_reg1(jreg1_q),
		.enable(enable_q),
		.decision(decision)
	);

	// counter load; registered so the fetch sees a clean value next cycle
	always_comb begin
		pc_d.valid = instr_valid;
		pc_d.taken = instr_valid & decision.taken;
		pc_d.pc = instr_valid ? decision.next_pc : pc_q.pc;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pc_q <= '{valid: 1'b0, taken: 1'b0, pc: mcj_pkg::PC_RESET};
		end else begin
			pc_q <= pc_d;
		end
	end

	// outputs come straight off the flops, no logic behind the register
	assign pc_load = pc_q.valid;
	assign pc_taken = pc_q.taken;
	assign core_program_counter = pc_q.pc;

	// ------------------------------------------------------------------
	// observed decode status
	// ------------------------------------------------------------------

	// status only moves on a recognised jump, so plain words leave it alone
	always_comb begin
		last_taken_d = last_taken_q;
		last_id_d = last_id_q;
		last_start_d = last_start_q;
		if (instr_valid && (decision.is_id_jump || decision.is_start_jump)) begin
			last_taken_d = decision.taken;
			last_id_d = decision.is_id_jump;
			last_start_d = decision.is_start_jump;
		end
	end

	// status flops; only reset clears them, the bus cannot
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			last_taken_q <= 1'b0;
			last_id_q <= 1'b0;
			last_start_q <= 1'b0;
		end else begin
			last_taken_q <= last_taken_d;
			last_id_q <= last_id_d;
			last_start_q <= last_start_d;
		end
	end

	// ------------------------------------------------------------------
	// avalon-mm slave
	// ------------------------------------------------------------------

	// one wait state: first cycle stalls and prepares read data
	// a request held past its answer is served again after a fresh wait
	assign bus_req = avs_read | avs_write;
	assign wr_go = avs_write & ack_q;
	assign avs_waitrequest = bus_req & ~ack_q;
	assign avs_readdata = rdata_q;

	// read mux; unmapped offsets read zero
	always_comb begin
		ack_d = bus_req & ~ack_q;
		rdata_d = rdata_q;
		if (avs_read && !ack_q) begin
			rdata_d = 32'h0000_0000;
			case (avs_address)
				mcj_pkg::OFS_JUMP_REG0: rdata_d[mcj_pkg::PC_W-1:0] = jreg0_q;
				mcj_pkg::OFS_JUMP_REG1: rdata_d[mcj_pkg::PC_W-1:0] = jreg1_q;
				mcj_pkg::OFS_CONTROL: rdata_d[mcj_pkg::CTRL_ENABLE_BIT] = enable_q;
				mcj_pkg::OFS_STATUS: begin
					rdata_d[mcj_pkg::STAT_TAKEN_BIT] = last_taken_q;
					rdata_d[mcj_pkg::STAT_ID_BIT] = last_id_q;
					rdata_d[mcj_pkg::STAT_START_BIT] = last_start_q;
					rdata_d[mcj_pkg::STAT_PC_LSB +: mcj_pkg::PC_W] = pc_q.pc;
				end
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// writes land on the edge where waitrequest is low; lanes 0 and 1 only
	always_comb begin
		jreg0_d = jreg0_q;
		jreg1_d = jreg1_q;
		enable_d = enable_q;
		if (wr_go) begin
			case (avs_address)
				mcj_pkg::OFS_JUMP_REG0: begin
					jreg0_d = lane_merge(jreg0_q, avs_writedata, avs_byteenable);
				end
				mcj_pkg::OFS_JUMP_REG1: begin
					jreg1_d = lane_merge(jreg1_q, avs_writedata, avs_byteenable);
				end
				mcj_pkg::OFS_CONTROL: begin
					if (avs_byteenable[0]) enable_d = avs_writedata[mcj_pkg::CTRL_ENABLE_BIT];
				end
				default: enable_d = enable_q;
			endcase
		end
	end

	// handshake flops; reset drops any half-served request
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	// software-set registers; enable resets high so code runs at once
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			jreg0_q <= mcj_pkg::JUMP_REG_RESET;
			jreg1_q <= mcj_pkg::JUMP_REG_RESET;
			enable_q <= mcj_pkg::CTRL_ENABLE_RESET;
		end else begin
			jreg0_q <= jreg0_d;
			jreg1_q <= jreg1_d;
			enable_q <= enable_d;
		end
	end

endmodule : mcj_decode_top

// >>> mcj_decode_asserts.sv
// Purpose: port-level checks of the conditional jump decoder
// Assumes: one clock, asynchronous active-low reset
// Notes: enable is internal, so sequential-address checks use miss cases only
`timescale 1ns/1ps
module mcj_decode_asserts (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// fetch and counter
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic [9:0] instr_addr,
	input wire logic core_id,
	input wire logic [5:0] start_latched,
	input wire logic pc_load,
	input wire logic pc_taken,
	input wire logic [9:0] core_program_counter,
	// register bus
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest
);
	// ----------------------------------------------------------
	// decode helpers and properties
	// ----------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	logic id_jmp;
	logic st_jmp;
	logic [9:0] nxt;
	logic [9:0] tgt;
	// field decode, kept apart from the design's own decoder
	assign id_jmp = instr_word[15:6] == 10'h0bd;
	assign st_jmp = instr_word[15:11] == 5'h07 && instr_word[3:0] == 4'h1;
	assign nxt = instr_addr + 10'h001;
	assign tgt = instr_addr + {{5{instr_word[4]}}, instr_word[4:0]};
	property p_load; instr_valid |=> pc_load; endproperty
	a_load: assert property (p_load) else $error("no load after word");
	property p_idle; !instr_valid |=> !pc_load && $stable(core_program_counter); endproperty
	a_idle: assert property (p_idle) else $error("counter moved while idle");
	property p_taken; pc_taken |-> pc_load; endproperty
	a_taken: assert property (p_taken) else $error("taken without load");
	property p_id_hit; pc_taken && $past(id_jmp) |-> core_program_counter == $past(tgt);
	endproperty
	a_id_hit: assert property (p_id_hit) else $error("bad relative target");
	property p_id_miss; instr_valid && id_jmp && instr_word[5] != core_id
		|=> !pc_taken && core_program_counter == $past(nxt); endproperty
	a_id_miss: assert property (p_id_miss) else $error("id jump on wrong core");
	property p_st_miss; instr_valid && st_jmp && instr_word[10:5] != start_latched
		|=> !pc_taken && core_program_counter == $past(nxt); endproperty
	a_st_miss: assert property (p_st_miss) else $error("start jump on mismatch");
	property p_other; instr_valid && !id_jmp && !st_jmp
		|=> !pc_taken && core_program_counter == $past(nxt); endproperty
	a_other: assert property (p_other) else $error("plain word jumped");
	property p_wait; $rose(avs_read) || $rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("wait state count wrong");
	c_id: cover property (pc_taken && $past(id_jmp));
	c_st: cover property (pc_taken && $past(st_jmp));
	c_rd: cover property (avs_read && !avs_waitrequest);
endmodule : mcj_decode_asserts
bind mcj_decode_top mcj_decode_asserts u_chk (.ref_clk(ref_clk), .resetn(resetn),
	.instr_valid(instr_valid), .instr_word(instr_word), .instr_addr(instr_addr),
	.core_id(core_id), .start_latched(start_latched), .pc_load(pc_load),
	.pc_taken(pc_taken), .core_program_counter(core_program_counter),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

// >>> mcj_code_model.sv
// Purpose: code store feeding instruction words to the decoder
// Assumes: bench preloads words by non-blocking writes
// Notes: idle word churns so a stale value never looks valid
`timescale 1ns/1ps
module mcj_code_model (
	// clock
	input wire logic ref_clk,
	// fetch request
	input wire logic fetch_en,
	input wire logic [9:0] fetch_addr,
	// fetched word
	output logic instr_valid,
	output logic [15:0] instr_word,
	output logic [9:0] instr_addr
);
	logic [15:0] mem [0:1023];
	logic [15:0] junk_q = 16'h1234;
	// changing pattern while not fetching
	always @(posedge ref_clk) junk_q <= ~junk_q ^ 16'h5a3c;
	assign instr_valid = fetch_en;
	assign instr_addr = fetch_addr;
	assign instr_word = fetch_en ? mem[fetch_addr] : junk_q;
endmodule : mcj_code_model

// >>> mcj_decode_top_tb.sv
// Purpose: self-checking bench of the conditional jump decoder
// Assumes: one wait state per bus access, one-cycle counter answer
// Notes: expectations queued by the driver, popped by the monitor
`timescale 1ns/1ps
module mcj_decode_top_tb;
	logic ref_clk, resetn, fetch_en, core_id, instr_valid, en, pc_load, pc_taken;
	logic avs_read, avs_write, avs_waitrequest;
	logic [9:0] fetch_addr, instr_addr, core_program_counter, jr0, jr1;
	logic [15:0] instr_word;
	logic [5:0] start_latched;
	logic [3:0] avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, r, rnd = 32'h5481638e;
	logic [10:0] q[$];
	logic [10:0] e;
	int fails = 0, checks_done = 0, i;
	mcj_code_model u_code (.ref_clk(ref_clk), .fetch_en(fetch_en), .fetch_addr(fetch_addr),
		.instr_valid(instr_valid), .instr_word(instr_word), .instr_addr(instr_addr));
	mcj_decode_top u_dut (.ref_clk(ref_clk), .resetn(resetn), .instr_valid(instr_valid),
		.instr_word(instr_word), .instr_addr(instr_addr), .core_id(core_id),
		.start_latched(start_latched), .pc_load(pc_load), .pc_taken(pc_taken),
		.core_program_counter(core_program_counter), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	// ----------------------------------------------------------
	// helpers
	// ----------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	// expected {taken, counter}
	function automatic logic [10:0] pred(logic [15:0] w, logic [9:0] a, logic c, logic [5:0] s);
		if (en && w[15:6] == 10'h0bd && w[5] == c)
			return {1'b1, a + {{5{w[4]}}, w[4:0]}};
		if (en && w[15:11] == 5'h07 && w[3:0] == 4'h1 && w[10:5] == s)
			return {1'b1, w[4] ? jr1 : jr0};
		return {1'b0, a + 10'h001};
	endfunction : pred
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : close_out
	// one instruction per call, back to back
	task automatic run(input logic [15:0] w, input logic [9:0] a, input logic c,
		input logic [5:0] s);
		@(posedge ref_clk);
		u_code.mem[a] <= w;
		fetch_addr <= a;
		fetch_en <= 1'b1;
		core_id <= c;
		start_latched <= s;
		q.push_back(pred(w, a, c, s));
		rnd = xs(rnd);
	endtask : run
	task automatic idle();
		@(posedge ref_clk);
		fetch_en <= 1'b0;
	endtask : idle
	// bus cycle held until waitrequest is seen low
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : av
	// ----------------------------------------------------------
	// clock, monitor, watchdog, main sequence
	// ----------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(negedge ref_clk) begin
		if (pc_load === 1'b1) begin
			e = q.size() ? q.pop_front() : 11'h7ff;
			check({21'h0, pc_taken, core_program_counter}, {21'h0, e});
		end
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		close_out();
	end
	initial begin
		{resetn, fetch_en, fetch_addr, core_id, start_latched} = '0;
		{avs_address, avs_read, avs_write, avs_writedata} = '0;
		avs_byteenable = 4'hf;
		{en, jr0, jr1} = {1'b1, 10'h3a5, 10'h15a};
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		av(0, 4'h8, 0);
		check(r, 32'h1);
		av(0, 4'h0, 0);
		check(r, 32'h0);
		av(1, 4'h0, {22'h0, jr0});
		av(1, 4'h4, {22'h0, jr1});
		av(0, 4'h4, 0);
		check(r, {22'h0, jr1});
		av(0, 4'h2, 0);
		check(r, 32'h0);
		for (i = 0; i < 128; i++) run({10'h0bd, i[5:0]}, rnd[9:0], i[6], rnd[15:10]);
		for (i = 0; i < 128; i++)
			run({5'h07, i[5:0], i[6], 4'h1}, rnd[9:0], rnd[10], rnd[20] ? i[5:0] : rnd[5:0]);
		for (i = 0; i < 300; i++) begin
			if (rnd[27]) idle();
			run(rnd[15:0], rnd[25:16], rnd[26], rnd[31:26]);
		end
		run({5'h07, 6'h21, 1'b1, 4'h1}, 10'h040, 1'b0, 6'h21);
		idle();
		av(0, 4'hc, 0);
		check(r, {6'h0, jr1, 13'h0, 3'b101});
		av(1, 4'hc, 32'hffffffff);
		av(0, 4'hc, 0);
		check(r, {6'h0, jr1, 13'h0, 3'b101});
		av(1, 4'h8, 0);
		en = 1'b0;
		run({10'h0bd, 1'b0, 5'h03}, 10'h100, 1'b0, 6'h0);
		idle();
		av(1, 4'h8, 1);
		en = 1'b1;
		run({10'h0bd, 1'b0, 5'h10}, 10'h000, 1'b0, 6'h0);
		idle();
		repeat (4) @(posedge ref_clk);
		check(q.size(), 0);
		// mid-run reset: registers and status must fall back to reset values
		@(posedge ref_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		av(0, 4'h4, 0);
		check(r, 32'h0);
		av(0, 4'h8, 0);
		check(r, 32'h1);
		av(0, 4'hc, 0);
		check(r, 32'h0);
		close_out();
	end
endmodule : mcj_decode_top_tb
